// *** sar_conv_ctrl.sv ***
// Conversion controller for an eight-channel simultaneous converter:
// trigger handling, busy, result coding and storage, range, bandwidth
// and reference selection, with an AHB-Lite register slave.
// Assumes converter words arrive in clk domain as offset binary.
`timescale 1ns/1ns
`default_nettype none
module sar_conv_ctrl
  import sar_ctrl_pkg::*;
#(
  parameter int NCH = sar_ctrl_pkg::CHANNELS,
  parameter int RBITS = sar_ctrl_pkg::RES_BITS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire sar_ctrl_pkg::pins_s pins,
  input wire logic [NCH-1:0][RBITS-1:0] sar_code,
  output sar_ctrl_pkg::afe_ctrl_s afe,
  output logic busy,
  output logic sw_mode,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  import sar_ctrl_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ctrl_s q;
  ctrl_s n;
  pins_s pin_s;
  logic trig_rise;
  logic ext_clk;
  logic step;
  logic osc_tick;
  logic addr_ok;
  logic [7:0] a_idx;
  logic [2:0] pair;
  logic mem_we;
  logic [RBITS-1:0] mem_wdata;
  logic mem_re;
  logic [RBITS-1:0] mem_rdata;
  logic [NCH-1:0][RANGE_W-1:0] eff_range;

  // ****************************************************************
  // Pin synchronisation and leaf blocks
  // ****************************************************************

  // All pins pass two flip-flops before any logic reads them.
  pin_sync #(
    .W($bits(pins_s))
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(pins),
    .sync_out(pin_s)
  );

  // Results of the last completed set until storing of the next set begins; readable at any time.
  result_mem #(
    .WIDTH(RBITS),
    .DEPTH(NCH)
  ) u_mem (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(mem_we),
    .wr_addr(q.ch),
    .wr_data(mem_wdata),
    .rd_en(mem_re),
    .rd_addr(a_idx[2:0]),
    .rd_data(mem_rdata)
  );

  // ****************************************************************
  // Mode and range decode
  // ****************************************************************

  // Software mode is the all-high oversampling pin pattern.
  assign sw_mode = (pin_s.oversampling_select_pins == SW_MODE_PINS);

  // Range per channel: registers in software mode, else the range pin.
  for (genvar i = 0; i < NCH; i++) begin : g_range
    assign eff_range[i] = sw_mode ? q.ranges[i] :
        (pin_s.range_hi ? R_SE_BI_10V : R_SE_BI_5V);
  end

  // External step clock only in software mode with the option set.
  assign ext_clk = sw_mode & q.cfg_ext;
  assign trig_rise = pin_s.trigger & ~q.trig_prev;
  assign osc_tick = (q.div_cnt == 8'(OSC_DIV - 1));
  assign step = ext_clk ? trig_rise : osc_tick;

  // Bus address phase decode.
  assign addr_ok = hsel & htrans[1] & hready;
  assign a_idx = haddr[9:2];
  assign mem_re = addr_ok & ~hwrite &
      (a_idx >= IDX_RESULT_BASE) & (a_idx <= IDX_RESULT_LAST);
  assign pair = 3'(q.wr_idx - IDX_RANGE_FIRST);

  // Storing: one channel word per cycle, coded by its range.
  assign mem_we = (q.st == ST_STORE);
  assign mem_wdata = code_result(sar_code[q.ch],
      q.eff[q.ch]);

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Fills the next copy of the whole state.
  always_comb begin
    n = q;
    n.sample = 1'b0;
    n.trig_prev = pin_s.trigger;
    n.eff = eff_range;
    // Reference mode follows the select pin from reset release on.
    n.ref_int = pin_s.ref_select;

    // Register writes in the data phase.
    n.wr_pend = addr_ok & hwrite;
    if (addr_ok) begin
      n.wr_idx = a_idx;
    end
    if (q.wr_pend) begin
      if (q.wr_idx == IDX_CONFIG) begin
        n.cfg_ext = hwdata[CFG_EXTCLK_BIT];
      end else if (q.wr_idx == IDX_BANDWIDTH) begin
        n.bw = hwdata[NCH-1:0];
      end else if (q.wr_idx >= IDX_RANGE_FIRST &&
                   q.wr_idx <= IDX_RANGE_LAST) begin
        n.ranges[{pair[1:0], 1'b0}] = hwdata[3:0];
        n.ranges[{pair[1:0], 1'b1}] = hwdata[7:4];
      end
    end

    // Register reads: data captured in the address phase.
    n.rd_res = mem_re;
    if (addr_ok & ~hwrite) begin
      n.rdata = '0;
      if (a_idx == IDX_STATUS) begin
        n.rdata[ST_BUSY_BIT] = busy;
        n.rdata[ST_READY_BIT] = q.ready;
        n.rdata[ST_SWMODE_BIT] = sw_mode;
        n.rdata[ST_REFINT_BIT] = q.ref_int;
        // Reading status consumes the fresh-data flag.
        n.ready = 1'b0;
      end else if (a_idx == IDX_CONFIG) begin
        n.rdata[CFG_EXTCLK_BIT] = q.cfg_ext;
      end else if (a_idx == IDX_BANDWIDTH) begin
        n.rdata[NCH-1:0] = q.bw;
      end else if (a_idx >= IDX_RANGE_FIRST &&
                   a_idx <= IDX_RANGE_LAST) begin
        n.rdata[7:0] = {q.ranges[{a_idx[1:0] - 2'h3, 1'b1}],
                        q.ranges[{a_idx[1:0] - 2'h3, 1'b0}]};
      end
    end

    // Conversion sequencer.
    case (q.st)
      ST_IDLE: begin
        if (trig_rise) begin
          n.st = ST_CONV;
          n.sample = 1'b1;
          n.bit_cnt = '0;
          n.div_cnt = '0;
        end
      end
      ST_CONV: begin
        // Trigger edges here only step an external clock.
        n.div_cnt = osc_tick ? 8'h00 : q.div_cnt + 8'h01;
        if (step) begin
          if (q.bit_cnt == 5'(RBITS - 1)) begin
            n.st = ST_STORE;
            n.ch = '0;
          end else begin
            n.bit_cnt = q.bit_cnt + 5'h01;
          end
        end
      end
      ST_STORE: begin
        if (q.ch == 3'(NCH - 1)) begin
          n.st = ST_IDLE;
          n.ready = 1'b1;
        end else begin
          n.ch = q.ch + 3'h1;
        end
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Registers the whole state; constants only under reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.cfg_ext <= CFG_EXTCLK_RST;
      q.bw <= BW_RST;
      q.ranges <= {NCH{RANGE_RST}};
      q.eff <= {NCH{RANGE_RST}};
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Busy spans conversion and storing of every channel.
  assign busy = (q.st != ST_IDLE);

  // Front-end controls.
  assign afe.sample = q.sample;
  assign afe.acquire = ~busy;
  assign afe.ref_int_en = q.ref_int;
  assign afe.bw_high = q.bw;
  assign afe.range = q.eff;

  // Bus answer: no wait states, always OKAY; results come from the
  // previous set until storing of the new set begins.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rd_res ? {{(32 - RBITS){1'b0}}, mem_rdata} :
      q.rdata;

endmodule // sar_conv_ctrl
`default_nettype wire

// *** sar_ctrl_pkg.sv ***
// Package for the simultaneous conversion controller: constants, types
// and coding helpers shared by the controller, its checker and the bench.
// Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
package sar_ctrl_pkg;

  // ****************************************************************
  // Sizes and timing
  // ****************************************************************
  localparam int CHANNELS = 8;
  localparam int RES_BITS = 18;
  localparam int RANGE_W = 4;
  localparam int CLK_MHZ = 125;
  // Conversion duration in ns; value chosen as a plain default.
  localparam int CONV_TIME_NS = 800;
  localparam int CONV_CYCLES = CONV_TIME_NS * CLK_MHZ / 1000;
  // Internal oscillator step: all bit decisions fit the duration.
  localparam int OSC_DIV = CONV_CYCLES / RES_BITS;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] IDX_STATUS = 8'h01;
  localparam logic [7:0] IDX_CONFIG = 8'h02;
  localparam logic [7:0] IDX_RANGE_FIRST = 8'h03;
  localparam logic [7:0] IDX_RANGE_LAST = 8'h06;
  localparam logic [7:0] IDX_BANDWIDTH = 8'h07;
  localparam logic [7:0] IDX_RESULT_BASE = 8'h10;
  localparam logic [7:0] IDX_RESULT_LAST = 8'h17;

  // Field positions.
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_SWMODE_BIT = 2;
  localparam int ST_REFINT_BIT = 3;
  localparam int CFG_EXTCLK_BIT = 0;

  // ****************************************************************
  // Range codes and reset values
  // ****************************************************************
  localparam logic [3:0] R_SE_BI_2V5 = 4'h0;
  localparam logic [3:0] R_SE_BI_5V = 4'h1;
  localparam logic [3:0] R_SE_BI_6V25 = 4'h2;
  localparam logic [3:0] R_SE_BI_10V = 4'h3;
  localparam logic [3:0] R_SE_BI_12V5 = 4'h4;
  localparam logic [3:0] R_SE_UNI_5V = 4'h5;
  localparam logic [3:0] R_SE_UNI_10V = 4'h6;
  localparam logic [3:0] R_SE_UNI_12V5 = 4'h7;
  localparam logic [3:0] R_DIFF_5V = 4'h8;
  localparam logic [3:0] R_DIFF_10V = 4'h9;
  localparam logic [3:0] R_DIFF_12V5 = 4'hA;
  localparam logic [3:0] R_DIFF_20V = 4'hB;
  localparam logic [3:0] RANGE_RST = 4'h3;
  localparam logic [7:0] BW_RST = 8'h00;
  localparam logic CFG_EXTCLK_RST = 1'b0;
  localparam logic [2:0] SW_MODE_PINS = 3'h7;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_STORE} conv_state_e;

  // Pins from outside the clock domain.
  typedef struct packed {
    logic trigger;
    logic range_hi;
    logic ref_select;
    logic [2:0] oversampling_select_pins;
  } pins_s;

  // Controls toward the analog front end and converters.
  typedef struct packed {
    logic sample;
    logic acquire;
    logic ref_int_en;
    logic [CHANNELS-1:0] bw_high;
    logic [CHANNELS-1:0][RANGE_W-1:0] range;
  } afe_ctrl_s;

  // Whole state of the controller.
  typedef struct packed {
    conv_state_e st;
    logic [4:0] bit_cnt;
    logic [7:0] div_cnt;
    logic [2:0] ch;
    logic sample;
    logic trig_prev;
    logic ready;
    logic ref_int;
    logic cfg_ext;
    logic [CHANNELS-1:0] bw;
    logic [CHANNELS-1:0][RANGE_W-1:0] ranges;
    logic [CHANNELS-1:0][RANGE_W-1:0] eff;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic rd_res;
    logic [31:0] rdata;
  } ctrl_s;

  // True for straight-binary ranges.
  function automatic logic is_unipolar(input logic [3:0] r);
    return (r == R_SE_UNI_5V) || (r == R_SE_UNI_10V) ||
           (r == R_SE_UNI_12V5);
  endfunction

  // Converts an offset-binary converter word to the output coding.
  function automatic logic [RES_BITS-1:0] code_result(
      input logic [RES_BITS-1:0] raw, input logic [3:0] r);
    if (is_unipolar(r)) begin
      return raw;
    end
    return {~raw[RES_BITS-1], raw[RES_BITS-2:0]};
  endfunction

endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser for a group of pin levels.
// Assumes the levels are quasi-static or single-bit events.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pin_sync
`default_nettype wire

// *** result_mem.sv ***
// Result store: one write port, one read port, registered read data.
// Assumes one clock; a read and a write may meet in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module result_mem #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Storage array, cleared at reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Registered read port; old word is returned on a colliding write.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_q[rd_addr];
    end
  end
endmodule // result_mem
`default_nettype wire

// *** sar_conv_checker.sv ***
// Checker for the conversion controller, watching its top ports only.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module sar_conv_checker
  import sar_ctrl_pkg::*;
#(
  parameter int NCH = CHANNELS,
  parameter int RBITS = RES_BITS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire sar_ctrl_pkg::pins_s pins,
  input wire sar_ctrl_pkg::afe_ctrl_s afe,
  input wire logic busy,
  input wire logic sw_mode
);
  // ********************
  // Helpers
  // ********************
  localparam int BUSY_CYC = RBITS * OSC_DIV + NCH;
  logic [7:0] run_q;
  logic [7:0] run_d;
  logic [1:0] up_q;
  logic settled;
  logic [CHANNELS-1:0][RANGE_W-1:0] hw_rng;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Busy run length so far, and the range the range pin asks for.
  assign run_d = busy ? run_q + 8'h01 : 8'h00;
  // Pins need three edges after reset release to reach the outputs.
  assign settled = (up_q == 2'h3);
  assign hw_rng = pins.range_hi ? {CHANNELS{R_SE_BI_10V}} :
    {CHANNELS{R_SE_BI_5V}};
  // Counts consecutive busy cycles and the settling edges after reset.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run_q <= 8'h00;
      up_q <= 2'h0;
    end else begin
      run_q <= run_d;
      if (!settled) begin
        up_q <= up_q + 2'h1;
      end
    end
  end
  // ********************
  // Assertions
  // ********************
  chk_sample_busy: assert property ($rose(busy) |-> afe.sample)
    else $error("busy rose without a sample pulse");
  chk_no_restart: assert property (
    afe.sample |-> $rose(busy) ##1 !afe.sample)
    else $error("sample pulse outside the start of busy");
  chk_trig_start: assert property (
    !busy && $rose(pins.trigger) |-> ##[1:4] busy)
    else $error("idle trigger edge did not start busy");
  chk_busy_min: assert property ($fell(busy) |-> run_q >= BUSY_CYC)
    else $error("busy fell before all channels were stored");
  chk_busy_time: assert property (
    $fell(busy) && !sw_mode |-> run_q == BUSY_CYC)
    else $error("internal conversion time is wrong");
  chk_acq_start: assert property ($fell(busy) |-> $rose(afe.acquire))
    else $error("acquisition did not start at busy fall");
  chk_ref_mode: assert property (
    (settled && $stable(pins.ref_select))[*4] |->
    afe.ref_int_en == pins.ref_select)
    else $error("internal reference does not follow its select pin");
  chk_hw_range: assert property (
    (settled && !sw_mode && $stable(pins.range_hi))[*4] |->
    afe.range == hw_rng)
    else $error("hardware range does not follow the range pin");
  chk_sw_decode: assert property (
    $stable(pins.oversampling_select_pins)[*3] |->
    sw_mode == (pins.oversampling_select_pins == SW_MODE_PINS))
    else $error("software mode decode is wrong");
  // Main scenarios reached.
  cov_conv_done: cover property ($fell(busy));
  cov_sw_sample: cover property (afe.sample && sw_mode);
  cov_ref_on: cover property ($rose(afe.ref_int_en));
endmodule // sar_conv_checker
bind sar_conv_ctrl sar_conv_checker #(.NCH(NCH), .RBITS(RBITS)) chk_u (
  .clk(clk), .arst_n(arst_n), .pins(pins), .afe(afe), .busy(busy),
  .sw_mode(sw_mode));
`default_nettype wire

// *** trig_source.sv ***
// Host-side trigger source: one start edge plus optional step edges.
// Assumes the same clock as the controller; idles low between frames.
`timescale 1ns/1ns
`default_nettype none
module trig_source (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic fire,
  input wire logic [4:0] steps,
  input wire logic [3:0] half,
  output logic trigger,
  output logic active
);
  // ********************
  // Edge generator
  // ********************
  logic [5:0] left_q;
  logic [3:0] ph_q;
  // Busy while edges remain; a new request during a frame is ignored, not held.
  assign active = left_q != 6'h00;
  // Square wave of fixed period, so step edges come without jitter.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      left_q <= 6'h00;
      ph_q <= 4'h0;
      trigger <= 1'b0;
    end else if (fire && !active) begin
      left_q <= {1'b0, steps} + 6'h01;
      ph_q <= half;
      trigger <= 1'b1;
    end else if (active) begin
      if (ph_q > 4'h1) begin
        ph_q <= ph_q - 4'h1;
      end else begin
        ph_q <= half;
        trigger <= ~trigger;
        if (trigger) begin
          left_q <= left_q - 6'h01;
        end
      end
    end
  end
endmodule // trig_source
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the conversion controller over AHB-Lite.
// Assumes the bound checker and trig_source as the trigger driver.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import sar_ctrl_pkg::*;
  // ********************
  // Signals and instances
  // ********************
  localparam int BUSY_CYC = RES_BITS * OSC_DIV + CHANNELS;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic range_hi = 1'b1;
  logic ref_sel = 1'b1;
  logic [2:0] os_pins = 3'h0;
  logic fire = 1'b0;
  logic [4:0] steps = 5'h00;
  logic [3:0] half = 4'h4;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [CHANNELS-1:0][RES_BITS-1:0] sar_code = '0;
  logic trig, trig_busy, busy, sw_mode, hready, hresp;
  logic [31:0] hrdata;
  pins_s pins;
  afe_ctrl_s afe;
  int err_total = 0;
  int checks = 0;
  int run = 0;
  int last_run = 0;
  // Pin group seen by the controller.
  assign pins = '{trigger: trig, range_hi: range_hi, ref_select: ref_sel,
    oversampling_select_pins: os_pins};
  sar_conv_ctrl dut_u (.clk(clk), .arst_n(arst_n), .pins(pins),
    .sar_code(sar_code), .afe(afe), .busy(busy), .sw_mode(sw_mode),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp));
  trig_source src_u (.clk(clk), .arst_n(arst_n), .fire(fire),
    .steps(steps), .half(half), .trigger(trig), .active(trig_busy));
  // Clock and busy run length measured at falling edges.
  always #4 clk = ~clk;
  always @(negedge clk) begin
    if (busy === 1'b1) begin
      run <= run + 1;
    end else if (run != 0) begin
      last_run <= run;
      run <= 0;
    end
  end
  // ********************
  // Helpers
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    @(posedge clk);
    for (int n = 0; n < 20 && hready !== 1'b1; n++) @(posedge clk);
  endtask
  task automatic ahb(input logic wr, input logic [7:0] idx,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {22'h000000, idx, 2'b00};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rd = hrdata;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 400 && busy !== lvl; n++) @(negedge clk);
  endtask
  function automatic logic [17:0] pat(input int k, input logic b);
    return {k[2:0] ^ {b, b, b}, 15'h0ABC + 15'(k)};
  endfunction
  task automatic go(input logic [4:0] n, input logic [3:0] h);
    while (trig_busy) @(posedge clk);
    steps <= n;
    half <= h;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task automatic conv(input logic b, input logic [4:0] n);
    @(posedge clk);
    for (int k = 0; k < CHANNELS; k++) sar_code[k] <= pat(k, b);
    go(n, 4'h4);
    wait_busy(1'b1);
  endtask
  task automatic res_chk(input logic b, input logic [7:0] uni);
    logic [31:0] r;
    logic [17:0] e;
    wait_busy(1'b0);
    ahb(1'b0, IDX_STATUS, 32'h0, r);
    chk(r & 32'h3, 32'h2);
    ahb(1'b0, IDX_STATUS, 32'h0, r);
    chk(r & 32'h2, 32'h0);
    for (int k = 0; k < CHANNELS; k++) begin
      ahb(1'b0, IDX_RESULT_BASE + 8'(k), 32'h0, r);
      e = uni[k] ? pat(k, b) : pat(k, b) ^ 18'h20000;
      chk(r, {14'h0000, e});
    end
  endtask
  // ********************
  // Scenarios
  // ********************
  task automatic t_regs();
    logic [31:0] r;
    for (int i = 3; i <= 6; i++) begin
      ahb(1'b0, 8'(i), 32'h0, r);
      chk(r & 32'hFF, 32'h33);
    end
    ahb(1'b0, IDX_BANDWIDTH, 32'h0, r);
    chk(r, 32'h0);
    ahb(1'b1, IDX_BANDWIDTH, 32'hA5, r);
    ahb(1'b1, 8'h08, 32'hFFFFFFFF, r);
    ahb(1'b0, 8'h08, 32'h0, r);
    chk(r, 32'h0);
    chk(afe.bw_high, 32'hA5);
    chk(hresp, 32'h0);
    chk(hready, 32'h1);
    $display("register test done");
  endtask
  task automatic t_hw();
    logic [31:0] r;
    conv(1'b0, 5'h00);
    res_chk(1'b0, 8'h00);
    chk(last_run, BUSY_CYC);
    chk(afe.acquire, 32'h1);
    range_hi <= 1'b0;
    conv(1'b1, 5'h00);
    ahb(1'b0, IDX_RESULT_BASE, 32'h0, r);
    chk(r, {14'h0000, pat(0, 1'b0) ^ 18'h20000});
    go(5'h00, 4'h4);
    res_chk(1'b1, 8'h00);
    chk(busy, 32'h0);
    chk(last_run, BUSY_CYC);
    chk(afe.range, {CHANNELS{R_SE_BI_5V}});
    $display("hardware mode test done");
  endtask
  task automatic t_sw();
    logic [31:0] r;
    @(posedge clk);
    os_pins <= SW_MODE_PINS;
    ahb(1'b1, IDX_RANGE_FIRST, 32'hB6, r);
    ahb(1'b1, 8'h04, 32'h75, r);
    ahb(1'b1, 8'h05, 32'h42, r);
    ahb(1'b1, IDX_RANGE_LAST, 32'h08, r);
    range_hi <= 1'b1;
    ahb(1'b0, IDX_STATUS, 32'h0, r);
    chk(r & 32'hC, 32'hC);
    conv(1'b0, 5'h00);
    chk(afe.range, 32'h084275B6);
    res_chk(1'b0, 8'h0D);
    $display("software mode test done");
  endtask
  task automatic t_ext();
    logic [31:0] r;
    ahb(1'b1, IDX_CONFIG, 32'h1, r);
    conv(1'b1, 5'h12);
    while (trig_busy) @(negedge clk);
    chk(busy, 32'h1);
    res_chk(1'b1, 8'h0D);
    chk(32'(last_run >= 18 * 8), 32'h1);
    ahb(1'b1, IDX_CONFIG, 32'h0, r);
    os_pins <= 3'h0;
    $display("step clock test done");
  endtask
  task automatic t_ref();
    ref_sel <= 1'b0;
    repeat (5) @(negedge clk);
    chk(afe.ref_int_en, 32'h0);
    @(posedge clk);
    ref_sel <= 1'b1;
    repeat (5) @(negedge clk);
    chk(afe.ref_int_en, 32'h1);
    @(posedge clk);
    ref_sel <= 1'b0;
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(negedge clk);
    chk(afe.ref_int_en, 32'h0);
    chk(afe.bw_high, 32'h0);
    $display("reference test done");
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence after a three-cycle reset.
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    repeat (5) @(negedge clk);
    chk(afe.ref_int_en, 32'h1);
    t_regs();
    t_hw();
    t_sw();
    t_ext();
    t_ref();
    finish_test();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #160000;
    err_total++;
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
